// File: hdl/nts_pkg.sv
// Purpose: Shared constants and types for the tag host serial port.
// Assumes: 100 MHz system clock; serial clock sampled as an ordinary input.
// Notes:   Mode codes are the top three bits of the first byte; the command code is the top two bits.
package nts_pkg;

  // ==========================================================================
  // Mode codes
  localparam logic [2:0] MODE_REG_WR = 3'h0;
  localparam logic [2:0] MODE_REG_RD = 3'h1;
  localparam logic [2:0] MODE_EE_WR = 3'h2;
  localparam logic [2:0] MODE_EE_RD = 3'h3;
  localparam logic [2:0] MODE_BUF_LD = 3'h4;
  localparam logic [2:0] MODE_BUF_RD = 3'h5;
  localparam logic [1:0] MODE_CMD = 2'h3;

  // ==========================================================================
  // Sizes and answers
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] EE_BLOCK_LAST = 2'h3;
  localparam logic [5:0] BUF_LOAD_MAX = 6'h20;
  localparam logic [7:0] CMD_ACCEPTED = 8'h01;
  localparam logic [7:0] CMD_REJECTED = 8'h02;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int EE_PROG_TYP_US = 8300;
  localparam int EE_PROG_MAX_US = 9500;
  localparam int EE_PROG_CYC = EE_PROG_TYP_US * CLK_MHZ;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic sclk;
    logic ss_n;
    logic mosi;
  } nts_pins_t;

  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
    logic [7:0] data;
  } nts_req_t;

endpackage : nts_pkg

// File: hdl/nts_spi_port.sv
// Purpose: Serial slave host port: registers, EEPROM, buffers, commands.
// Assumes: Serial clock far slower than clk_in; memories are outside.
// Notes:   Data shifts on sampled serial clock edges.
// Overview of operation
// [RL1] First three bits select mode; logic held reset while select high.
// [RL2] Register write: address byte, each data byte commits at its last bit.
// [RL3] Select rising mid-byte discards that byte; register unchanged.
// [RL4] Writes to missing or read-only registers are ignored.
// [RL5] Register read returns bytes MSB first, address incrementing.
// [RL6] Input sampled on falling edge; output changes on rising edge.
// [RL7] Reads of missing registers return zero.
// [RL8] EEPROM address byte: block address in bits seven to one.
// [RL9] EEPROM write is mode, address, four bytes; programs at select rise.
// [RL10] Programming completes and raises write-done within 9.5 ms.
// [RL11] EEPROM read streams four-byte blocks, address auto-advancing.
// [RL12] Missing EEPROM block returns zero data.
// [RL13] Master keeps serial clock at or below 1 MHz for EEPROM reads.
// [RL14] Mode 100b loads up to 32 bytes into the transmit buffer.
// [RL15] Mode 101b returns every byte from the receive buffer.
// [RL16] Partly shifted buffer read byte still counts as read.
// [RL17] Mode 11b is direct command; six code bits then argument byte.
// [RL18] Argument byte returns 01h accepted or 02h rejected.
// [RL19] Pull-down enabled on serial output while tristated if option set.
// [RL20] Serial output tristated except while shifting read data.
`timescale 1ns/100ps
module nts_spi_port (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic sclk_in,
  input wire logic ss_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_n_out,
  output logic miso_pd_out,
  input wire logic out_pulldown_enable_in,
  output nts_pkg::nts_req_t reg_wr_out,
  output logic [6:0] reg_rd_addr_out,
  input wire logic [7:0] reg_rd_data_in,
  input wire logic reg_rd_exists_in,
  input wire logic reg_wr_ok_in,
  output logic [6:0] ee_addr_out,
  output logic [1:0] ee_byte_out,
  input wire logic [7:0] ee_rd_data_in,
  input wire logic ee_exists_in,
  output logic [31:0] ee_wr_data_out,
  output logic ee_busy_out,
  output logic ee_done_out,
  output nts_pkg::nts_req_t buf_ld_out,
  output logic buf_rd_pop_out,
  input wire logic [7:0] buf_rd_data_in,
  output nts_pkg::nts_req_t cmd_out,
  input wire logic cmd_busy_in
);
  import nts_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_MODE = 6'h02,
    ST_ADDR = 6'h04,
    ST_DATA = 6'h08,
    ST_ARG = 6'h10,
    ST_DONE = 6'h20
  } nts_state_t;

  typedef struct packed {
    nts_state_t state;
    logic [2:0] mode;
    logic [7:0] shin;
    logic [2:0] bitn;
    logic [7:0] shout;
    logic       drive;
    logic [6:0] addr;
    logic [1:0] eebyte;
    logic [31:0] eedata;
    logic       eefull;
    logic [5:0] bufcnt;
    logic       partial;
    logic       sclk_d;
    logic       ss_d;
    logic [31:0] prog;
    logic       busy;
    logic       done;
    nts_req_t   regwr;
    nts_req_t   bufld;
    nts_req_t   cmd;
    logic       pop;
  } nts_st_t;

  nts_pins_t pins;
  nts_st_t st_reg;
  nts_st_t st_next;
  logic fall;
  logic rise;
  logic ss_rise;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;

  nts_sync u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .pins_in('{sclk: sclk_in, ss_n: ss_n_in, mosi: mosi_in}),
    .pins_out(pins)
  );

  // ==========================================================================
  // Edges of the filtered serial clock
  assign fall = st_reg.sclk_d & ~pins.sclk & ~pins.ss_n; // [RL6]
  assign rise = ~st_reg.sclk_d & pins.sclk & ~pins.ss_n; // [RL6]
  assign ss_rise = ~st_reg.ss_d & pins.ss_n;
  assign byte_in = {st_reg.shin[6:0], pins.mosi};

  // Source of the next byte to shift out, chosen by mode
  always_comb begin
    rd_byte = ZERO_BYTE;
    case (st_reg.mode)
      MODE_REG_RD: rd_byte = reg_rd_exists_in ? reg_rd_data_in
                                              : ZERO_BYTE; // [RL7]
      MODE_EE_RD: rd_byte = ee_exists_in ? ee_rd_data_in
                                         : ZERO_BYTE; // [RL12]
      MODE_BUF_RD: rd_byte = buf_rd_data_in; // [RL15]
      default: rd_byte = ZERO_BYTE;
    endcase
  end

  // ==========================================================================
  // Main sequencer
  always_comb begin
    st_next = st_reg;
    st_next.sclk_d = pins.sclk;
    st_next.ss_d = pins.ss_n;
    st_next.regwr.valid = 1'b0;
    st_next.bufld.valid = 1'b0;
    st_next.cmd.valid = 1'b0;
    st_next.pop = 1'b0;
    st_next.done = 1'b0;
    // Programming timer runs independently of select
    if (st_reg.busy) begin
      if (st_reg.prog == 32'h0) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1; // [RL10]
      end else begin
        st_next.prog = st_reg.prog - 32'h1;
      end
    end
    if (pins.ss_n) begin
      // Port held idle while deselected
      st_next.state = ST_IDLE; // [RL1]
      st_next.bitn = 3'h0;
      st_next.drive = 1'b0; // [RL20]
      st_next.shin = ZERO_BYTE;
      st_next.eefull = 1'b0;
      st_next.bufcnt = 6'h0;
      st_next.partial = 1'b0;
      if (ss_rise && st_reg.eefull && !st_reg.busy) begin
        st_next.busy = 1'b1; // [RL9]
        st_next.prog = EE_PROG_CYC - 1;
      end
      if (ss_rise && st_reg.partial && st_reg.mode == MODE_BUF_RD) begin
        st_next.pop = 1'b1; // [RL16]
      end
      // An unfinished register byte is simply dropped here [RL3]
    end else begin
      if (st_reg.state == ST_IDLE) begin
        st_next.state = ST_MODE;
      end
      if (rise && st_reg.drive) begin
        st_next.partial = 1'b1;
        if (st_reg.bitn != 3'h0) begin
          st_next.shout = {st_reg.shout[6:0], 1'b0}; // [RL6]
        end else if (st_reg.state == ST_DATA) begin
          // Fetch at the first rise: any pop has settled by then
          st_next.shout = rd_byte; // [RL5] [RL15]
          if (st_reg.mode == MODE_REG_RD) begin
            st_next.addr = st_reg.addr + 7'h1; // [RL5]
          end else if (st_reg.mode == MODE_EE_RD) begin
            st_next.eebyte = st_reg.eebyte + 2'h1;
            if (st_reg.eebyte == EE_BLOCK_LAST) begin
              st_next.addr = st_reg.addr + 7'h1; // [RL11]
            end
          end
        end
      end
      if (fall) begin
        st_next.shin = byte_in;
        st_next.bitn = st_reg.bitn + 3'h1;
        if (st_reg.bitn == BIT_LAST) begin
          st_next.partial = 1'b0;
          case (st_reg.state)
            ST_MODE: begin
              st_next.mode = byte_in[7:5]; // [RL1]
              st_next.addr = byte_in[6:0];
              if (byte_in[7:6] == MODE_CMD) begin
                st_next.state = ST_ARG; // [RL17]
                st_next.cmd.data = {2'h0, byte_in[5:0]};
                st_next.cmd.valid = ~cmd_busy_in;
                st_next.shout = cmd_busy_in ? CMD_REJECTED
                                            : CMD_ACCEPTED; // [RL18]
                st_next.drive = 1'b1;
              end else if (byte_in[7:5] == MODE_BUF_LD) begin
                st_next.state = ST_DATA; // [RL14]
              end else if (byte_in[7:5] == MODE_BUF_RD) begin
                // Head byte is fetched at the first rise, nothing popped yet
                st_next.state = ST_DATA; // [RL15]
                st_next.drive = 1'b1;
              end else begin
                st_next.state = ST_ADDR;
              end
            end
            ST_ADDR: begin
              st_next.state = ST_DATA;
              if (st_reg.mode[2:1] == MODE_EE_WR[2:1]) begin
                st_next.addr = byte_in[7:1]; // [RL8]
              end else begin
                st_next.addr = byte_in[6:0];
              end
              st_next.eebyte = 2'h0;
            end
            ST_DATA: begin
              case (st_reg.mode)
                MODE_REG_WR: begin
                  st_next.regwr.valid = reg_wr_ok_in; // [RL2] [RL4]
                  st_next.regwr.addr = st_reg.addr;
                  st_next.regwr.data = byte_in;
                  st_next.addr = st_reg.addr + 7'h1;
                end
                MODE_EE_WR: begin
                  if (!st_reg.eefull && !st_reg.busy) begin
                    st_next.eedata = {st_reg.eedata[23:0], byte_in};
                    st_next.eebyte = st_reg.eebyte + 2'h1;
                    st_next.eefull = st_reg.eebyte == EE_BLOCK_LAST; // [RL9]
                  end
                end
                MODE_BUF_LD: begin
                  if (st_reg.bufcnt != BUF_LOAD_MAX) begin
                    st_next.bufld.valid = 1'b1; // [RL14]
                    st_next.bufld.data = byte_in;
                    st_next.bufcnt = st_reg.bufcnt + 6'h1;
                  end
                end
                MODE_BUF_RD: begin
                  st_next.pop = 1'b1; // [RL15]
                end
                default: begin
                end
              endcase
            end
            ST_ARG: begin
              st_next.state = ST_DONE;
              st_next.drive = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
      // Register and EEPROM reads start driving at the end of the address byte
      if (st_reg.state == ST_DATA || (st_reg.state == ST_ADDR && fall &&
          st_reg.bitn == BIT_LAST)) begin
        if (fall && st_reg.bitn == BIT_LAST) begin
          if (st_reg.mode == MODE_REG_RD || st_reg.mode == MODE_EE_RD) begin
            st_next.drive = 1'b1; // [RL5] [RL11]
          end
        end
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_reg <= '{state: ST_IDLE, sclk_d: 1'b1, ss_d: 1'b1, default: '0};
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs. Each read byte is fetched at the first rise of its slot, so
  // the lookups beside the port must answer combinationally.
  assign miso_out = st_reg.shout[7];
  assign miso_oe_n_out = ~st_reg.drive; // [RL20]
  assign miso_pd_out = out_pulldown_enable_in & ~st_reg.drive; // [RL19]
  assign reg_wr_out = st_reg.regwr;
  assign reg_rd_addr_out = st_reg.addr;
  assign ee_addr_out = st_reg.addr;
  assign ee_byte_out = st_reg.eebyte;
  assign ee_wr_data_out = st_reg.eedata;
  assign ee_busy_out = st_reg.busy;
  assign ee_done_out = st_reg.done;
  assign buf_ld_out = st_reg.bufld;
  assign buf_rd_pop_out = st_reg.pop;
  assign cmd_out = st_reg.cmd;

  // ==========================================================================
  // Checks
  AST_TRISTATE_IDLE: assert property (@(posedge clk_in) disable iff
    (!rst_n_in) pins.ss_n && ce_in |=> miso_oe_n_out) // [RL20]
    else $error("output driven while deselected");
  AST_PULLDOWN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    miso_pd_out |-> miso_oe_n_out && out_pulldown_enable_in) // [RL19]
    else $error("pull-down while driving");
  AST_CMD_ANSWER: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_out.valid |-> !miso_oe_n_out && miso_out == 1'b0) // [RL18]
    else $error("command answer wrong");
  AST_EE_START: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(ee_busy_out) |-> pins.ss_n) // [RL9]
    else $error("programming started inside frame");
  AST_EE_DONE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ee_done_out |-> $past(ee_busy_out)) // [RL10]
    else $error("done without programming");
  AST_BUF_MAX: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $past(st_reg.bufcnt) == BUF_LOAD_MAX |-> !buf_ld_out.valid) // [RL14]
    else $error("buffer load overrun");
  AST_MISO_ON_RISE: assert property (@(posedge clk_in) disable iff
    (!rst_n_in) !miso_oe_n_out && $past(!miso_oe_n_out) &&
    $changed(miso_out) |-> $past(rise)) // [RL6]
    else $error("serial output changed off a rising edge");
  AST_RD_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && rise && st_reg.drive && st_reg.bitn == 3'h0 && st_reg.state ==
    ST_DATA && st_reg.mode == MODE_REG_RD && !reg_rd_exists_in |=>
    st_reg.shout == ZERO_BYTE) // [RL7]
    else $error("missing register not read as zero");
  AST_EE_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && rise && st_reg.drive && st_reg.bitn == 3'h0 && st_reg.state ==
    ST_DATA && st_reg.mode == MODE_EE_RD && !ee_exists_in |=>
    st_reg.shout == ZERO_BYTE) // [RL12]
    else $error("missing block not read as zero");
  AST_POP_MODE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    buf_rd_pop_out |-> st_reg.mode == MODE_BUF_RD) // [RL15]
    else $error("buffer pop outside buffer read");
  AST_DRIVE_READ: assert property (@(posedge clk_in) disable iff
    (!rst_n_in) !miso_oe_n_out |-> st_reg.state == ST_DATA ||
    st_reg.state == ST_ARG) // [RL20]
    else $error("output driven outside a read slot");
  AST_REG_WR_PULSE: assert property (@(posedge clk_in) disable iff
    (!rst_n_in) reg_wr_out.valid |=> !reg_wr_out.valid) // [RL2]
    else $error("register write not single pulse");
  AST_NO_WR_DESEL: assert property (@(posedge clk_in) disable iff
    (!rst_n_in) pins.ss_n && ce_in |=> !reg_wr_out.valid) // [RL3]
    else $error("write after deselect");

endmodule : nts_spi_port

// File: hdl/nts_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to clk_in.
// Notes:   Output changes only once stages two and three agree.
`timescale 1ns/100ps
module nts_sync (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire nts_pkg::nts_pins_t pins_in,
  output nts_pkg::nts_pins_t pins_out
);
  import nts_pkg::*;

  typedef struct packed {
    nts_pins_t s1;
    nts_pins_t s2;
    nts_pins_t s3;
    nts_pins_t q;
  } nts_sync_st_t;

  nts_sync_st_t st_reg;
  nts_sync_st_t st_next;

  // ==========================================================================
  // Filter
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pins_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.q = st_reg.s3;
    end
  end

  // Select idles high and the serial clock low, so the port comes out of
  // reset inactive and no false select edge follows reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_reg <= '{s1: 3'h2, s2: 3'h2, s3: 3'h2, q: 3'h2};
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign pins_out = st_reg.q;

endmodule : nts_sync

// File: test/nfc_tag_spi_host_port_tb.sv
// Purpose: Self-checking bench for the tag host serial port.
// Assumes: Registers and EEPROM beside the port are modelled here by address patterns, the buffer by a pop count.
// Notes:   EEPROM programming runs far past the run length; only its start
//          is checked.
`timescale 1ns/100ps
module nfc_tag_spi_host_port_tb;
  import nts_pkg::*;
  logic clk_in, rst_n_in, sclk, ss_n, mosi, miso, miso_oe_n, miso_pd;
  logic pd_opt, cmd_busy, ee_busy, ee_done, pop, miso_hold, miso_line;
  logic [6:0] rd_addr, ee_addr;
  logic [1:0] ee_byte;
  logic [31:0] ee_wdata;
  nts_req_t reg_wr, buf_ld, cmd;
  nts_req_t wr_q[$], ld_q[$], cmd_q[$];
  logic [7:0] rx_q[$];
  int pops, cycles, miscompares, checked;

  // ==========================================================================
  // Surroundings
  // Missing places answer with junk so that zeroing is really seen
  wire reg_ex = rd_addr < 7'h20;
  wire [7:0] reg_data = reg_ex ? {rd_addr, 1'b1} : 8'ha5;
  wire ee_ex = ee_addr < 7'h40;
  wire [7:0] ee_data = ee_ex ? {ee_addr[5:0], ee_byte} : 8'h5a;
  wire [7:0] buf_head = 8'hc0 + pops[7:0];
  always @(negedge clk_in) if (miso_oe_n === 1'b0) miso_hold <= miso;
  assign miso_line = (miso_oe_n === 1'b0) ? miso :
                     (miso_pd === 1'b1) ? 1'b0 : ~miso_hold;

  nts_spi_port i_nts_spi_port (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .sclk_in(sclk), .ss_n_in(ss_n), .mosi_in(mosi),
    .miso_out(miso), .miso_oe_n_out(miso_oe_n), .miso_pd_out(miso_pd),
    .out_pulldown_enable_in(pd_opt), .reg_wr_out(reg_wr),
    .reg_rd_addr_out(rd_addr), .reg_rd_data_in(reg_data),
    .reg_rd_exists_in(reg_ex), .reg_wr_ok_in(rd_addr < 7'h18),
    .ee_addr_out(ee_addr), .ee_byte_out(ee_byte), .ee_rd_data_in(ee_data),
    .ee_exists_in(ee_ex), .ee_wr_data_out(ee_wdata),
    .ee_busy_out(ee_busy), .ee_done_out(ee_done), .buf_ld_out(buf_ld),
    .buf_rd_pop_out(pop), .buf_rd_data_in(buf_head), .cmd_out(cmd),
    .cmd_busy_in(cmd_busy)
  );

  nts_master_model i_nts_master_model (
    .miso_line_in(miso_line), .sclk_out(sclk), .ss_n_out(ss_n),
    .mosi_out(mosi)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (reg_wr.valid === 1'b1) wr_q.push_back(reg_wr);
    if (buf_ld.valid === 1'b1) ld_q.push_back(buf_ld);
    if (cmd.valid === 1'b1) cmd_q.push_back(cmd);
    if (pop === 1'b1) pops++;
    cycles++;
    // Bound well above the roughly 15000 cycles the scenarios need
    if (cycles == 40000) begin
      miscompares++;
      conclude();
    end
  end

  // ==========================================================================
  // Checking
  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : report
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    report({24'h0, got}, {24'h0, exp});
  endtask : cmp_byte
  task automatic cmp_bit(input logic got, input logic exp);
    report({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask : cmp_word

  task automatic conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // Last byte may be cut short; keep_open leaves select low afterwards
  task automatic frame(input logic [7:0] tx[$], input int last_bits,
                       input bit keep_open);
    logic [7:0] rx;
    rx_q.delete();
    i_nts_master_model.start();
    foreach (tx[i]) begin
      i_nts_master_model.xfer(tx[i], (i == tx.size() - 1) ? last_bits : 8,
                              rx);
      rx_q.push_back(rx);
    end
    if (!keep_open) i_nts_master_model.stop();
    repeat (20) @(posedge clk_in);
  endtask : frame

  // ==========================================================================
  // Scenarios
  task automatic t_reg_write;
    wr_q.delete();
    frame('{8'h00, 8'h05, 8'h9c, 8'h3b, 8'h77}, 4, 0);
    cmp_word(wr_q.size(), 2);
    if (wr_q.size() >= 2) begin
      cmp_word({wr_q[0].addr, wr_q[0].data}, {7'h05, 8'h9c});
      cmp_word({wr_q[1].addr, wr_q[1].data}, {7'h06, 8'h3b});
    end
    frame('{8'h00, 8'h18, 8'h11}, 8, 0);
    frame('{8'h00, 8'h40, 8'h22}, 8, 0);
    cmp_word(wr_q.size(), 2);
  endtask : t_reg_write

  task automatic t_reg_read;
    frame('{8'h20, 8'h1e, 8'h00, 8'h00, 8'h00}, 8, 0);
    cmp_byte(rx_q[2], 8'h3d);
    cmp_byte(rx_q[3], 8'h3f);
    cmp_byte(rx_q[4], 8'h00);
  endtask : t_reg_read

  task automatic t_ee_read;
    i_nts_master_model.half_ns = 500.0;
    frame('{8'h7f, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00}, 8, 0);
    for (int k = 0; k < 8; k++) begin
      cmp_byte(rx_q[2 + k],
               (k < 4) ? 8'hfc + k[7:0] : 8'h00);
    end
    i_nts_master_model.half_ns = 62.5;
  endtask : t_ee_read

  task automatic t_buf_load;
    logic [7:0] tx[$];
    ld_q.delete();
    tx.push_back(8'h80);
    for (int i = 0; i < 33; i++) tx.push_back(8'h10 + i[7:0]);
    frame(tx, 8, 0);
    cmp_word(ld_q.size(), 32);
    if (ld_q.size() == 32) begin
      cmp_byte(ld_q[0].data, 8'h10);
      cmp_byte(ld_q[31].data, 8'h2f);
    end
  endtask : t_buf_load

  task automatic t_buf_read;
    int base;
    base = pops;
    frame('{8'ha0, 8'h00, 8'h00, 8'h00}, 3, 0);
    cmp_byte(rx_q[1], 8'hc0 + base[7:0]);
    cmp_byte(rx_q[2], 8'hc1 + base[7:0]);
    cmp_word(pops - base, 3);
  endtask : t_buf_read

  task automatic t_command;
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_in);
      #1 cmd_busy = b[0];
      cmd_q.delete();
      frame('{8'hea, 8'h00}, 8, 0);
      cmp_byte(rx_q[1], b ? CMD_REJECTED : CMD_ACCEPTED);
      if (!b) cmp_word(cmd_q.size(), 1);
      if (!b && cmd_q.size() == 1) begin
        cmp_byte(cmd_q[0].data & 8'h3f, 8'h2a);
      end
    end
    cmd_busy = 1'b0;
  endtask : t_command

  task automatic t_idle;
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_in);
      #1 pd_opt = p[0];
      repeat (4) @(posedge clk_in);
      cmp_bit(miso_oe_n, 1'b1);
      cmp_bit(miso_pd, p[0]);
    end
  endtask : t_idle

  // Programming takes far longer than the run, so only its start is seen
  task automatic t_ee_write;
    frame('{8'h40, 8'h25, 8'hde, 8'had, 8'hbe, 8'hef}, 8, 1);
    cmp_bit(ee_busy, 1'b0);
    i_nts_master_model.stop();
    repeat (20) @(posedge clk_in);
    cmp_bit(ee_busy, 1'b1);
    cmp_byte({1'b0, ee_addr}, 8'h12);
    cmp_word(ee_wdata, 32'hdeadbeef);
    cmp_bit(ee_done, 1'b0);
  endtask : t_ee_write

  initial begin
    rst_n_in = 1'b0;
    pd_opt = 1'b0;
    cmd_busy = 1'b0;
    miso_hold = 1'b0;
    repeat (16) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    repeat (8) @(posedge clk_in);
    t_idle();
    t_reg_write();
    t_reg_read();
    t_buf_load();
    t_buf_read();
    t_command();
    t_ee_read();
    t_ee_write();
    conclude();
  end
endmodule : nfc_tag_spi_host_port_tb

// File: test/nts_master_model.sv
// Purpose: Behavioural serial master that frames and clocks host transfers.
// Assumes: Serial clock idles low; the bench picks the half period.
// Notes:   Data out is inverted at each frame end and holds that value between frames.
`timescale 1ns/100ps
module nts_master_model (
  input wire logic miso_line_in,
  output logic sclk_out,
  output logic ss_n_out,
  output logic mosi_out
);
  realtime half_ns = 62.5;

  initial begin
    sclk_out = 1'b0;
    ss_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // Select low starts a fresh mode byte; the port is reset while high
  task automatic start;
    ss_n_out = 1'b0;
    #200;
  endtask : start

  task automatic stop;
    #100;
    ss_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #300;
  endtask : stop

  // Set data in the low phase, the device samples at the fall, and the
  // returned bit is taken at the same fall slow half period for
  // EEPROM reads is chosen by the bench
  task automatic xfer(input logic [7:0] tx, input int nbits,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      #20;
      mosi_out = tx[i];
      #(half_ns - 20);
      sclk_out = 1'b1;
      #(half_ns);
      rx[i] = miso_line_in;
      sclk_out = 1'b0;
    end
  endtask : xfer
endmodule : nts_master_model
